// ---- arf_pkg.sv ----
/*
 * Constants, field layout and types of the result and filter register block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses and one word per register.
 */
// How it works
// - Each converter trigger raises the conversion count by one, and at 0xFF it stays put.
// - In filter, burst average and average modes the threshold check waits for the count.
// - In accumulate, average and burst average modes the filter output is the accumulator shifted right.
// - In low-pass filter mode the filter output is the low-pass filter value.
// - Left format puts result bits 9..2 in the high byte and bits 1..0 in low bits 7..6.
// - Right format puts result bits 9..8 in high byte bits 1..0, upper six bits reserved.
// - Right format puts result bits 7..0 in the low byte.
// - With the source select set, the previous value takes the filter output at conversion start.
// - With the source select clear, the previous value takes the result at conversion start.
// - With the source select clear, the previous value keeps the result's justification.
// - The accumulator is a signed 16-bit value with the sign in its top bit.
`default_nettype none

package arf_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_CNT = 6'h04;
    localparam logic [5:0] OFS_FILT_HI = 6'h08;
    localparam logic [5:0] OFS_FILT_LO = 6'h0C;
    localparam logic [5:0] OFS_RES_HI = 6'h10;
    localparam logic [5:0] OFS_RES_LO = 6'h14;
    localparam logic [5:0] OFS_PREV_HI = 6'h18;
    localparam logic [5:0] OFS_PREV_LO = 6'h1C;

    // control word: byte 0 holds format, source and mode, byte 1 the shift
    localparam int CTRL_FMT_BIT = 0;
    localparam int CTRL_PSIS_BIT = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_MSB = 6;
    localparam int CTRL_SHIFT_LSB = 8;
    localparam int CTRL_SHIFT_MSB = 10;

    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD16_RESET = 16'h0000;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
    localparam logic [2:0] SHIFT_RESET = 3'h0;

    typedef enum logic [2:0] {
        ARF_MODE_BASIC = 3'b000,
        ARF_MODE_ACCUM = 3'b001,
        ARF_MODE_AVG = 3'b010,
        ARF_MODE_BURST = 3'b011,
        ARF_MODE_LPF = 3'b100
    } arf_mode_t;

    typedef enum logic {
        ARF_BUS_IDLE = 1'b0,
        ARF_BUS_ANSWER = 1'b1
    } arf_bus_t;
endpackage : arf_pkg

`default_nettype wire

// ---- arf_fmt.sv ----
/*
 * Justifies a 10-bit conversion result into a high and a low byte.
 * Assumes the caller registers the bytes; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module arf_fmt (
    input wire logic [9:0] value,
    input wire logic right_just,
    output logic [7:0] hi,
    output logic [7:0] lo
);
    always_comb begin
        if (right_just) begin
            hi = {6'h00, value[9:8]};
            lo = value[7:0];
        end else begin
            hi = value[9:2];
            lo = {value[1:0], 6'h00};
        end
    end
endmodule : arf_fmt

`default_nettype wire

// ---- arf_regs.sv ----
/*
 * Result-side registers of the converter: trigger counter, filter output,
 * justified result and previous value, reached over Avalon-MM.
 * Assumes the converter core gives one-cycle start and done pulses on clock.
 */
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module arf_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [arf_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_value,
    input wire logic [15:0] sum_accumulator,
    input wire logic [15:0] lpf_value,
    input wire logic [7:0] repeat_threshold,
    output logic threshold_check,
    output logic [15:0] filter_output,
    output logic result_format_bit,
    output logic [2:0] compute_mode
);
    import arf_pkg::*;

    typedef struct packed {
        arf_bus_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic fmt;
        logic psis;
        arf_mode_t mode;
        logic [2:0] shift;
        logic [7:0] cnt;
        logic [15:0] filt;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] prev_hi;
        logic [7:0] prev_lo;
        logic chk;
    } arf_state_t;

    arf_state_t s_q;
    arf_state_t s_d;
    logic [7:0] fmt_hi;
    logic [7:0] fmt_lo;
    logic [15:0] shifted;
    logic do_write;

    // modes whose threshold check is paced by the count
    function automatic logic paced_mode(input arf_mode_t m);
        paced_mode = (m == ARF_MODE_LPF) || (m == ARF_MODE_BURST) || (m == ARF_MODE_AVG);
    endfunction : paced_mode

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    arf_fmt u_fmt (
        .value(conv_value),
        .right_just(s_q.fmt),
        .hi(fmt_hi),
        .lo(fmt_lo)
    );

    // arithmetic shift keeps the sign of the accumulator
    assign shifted = 16'($signed(sum_accumulator) >>> s_q.shift);
    assign do_write = (s_q.bus == ARF_BUS_ANSWER) && avs_write;

    always_comb begin
        s_d = s_q;
        s_d.chk = 1'b0;

        // bus: one cycle of wait, then one cycle of answer
        case (s_q.bus)
            ARF_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    s_d.bus = ARF_BUS_ANSWER;
                    s_d.waitreq = 1'b0;
                    s_d.rdata = RDATA_UNMAPPED;
                    if (hit(avs_address, OFS_CTRL)) begin
                        s_d.rdata[CTRL_FMT_BIT] = s_q.fmt;
                        s_d.rdata[CTRL_PSIS_BIT] = s_q.psis;
                        s_d.rdata[CTRL_MODE_MSB:CTRL_MODE_LSB] = s_q.mode;
                        s_d.rdata[CTRL_SHIFT_MSB:CTRL_SHIFT_LSB] = s_q.shift;
                    end else if (hit(avs_address, OFS_CNT)) begin
                        s_d.rdata[7:0] = s_q.cnt;
                    end else if (hit(avs_address, OFS_FILT_HI)) begin
                        s_d.rdata[7:0] = s_q.filt[15:8];
                    end else if (hit(avs_address, OFS_FILT_LO)) begin
                        s_d.rdata[7:0] = s_q.filt[7:0];
                    end else if (hit(avs_address, OFS_RES_HI)) begin
                        s_d.rdata[7:0] = s_q.res_hi;
                    end else if (hit(avs_address, OFS_RES_LO)) begin
                        s_d.rdata[7:0] = s_q.res_lo;
                    end else if (hit(avs_address, OFS_PREV_HI)) begin
                        s_d.rdata[7:0] = s_q.prev_hi;
                    end else if (hit(avs_address, OFS_PREV_LO)) begin
                        s_d.rdata[7:0] = s_q.prev_lo;
                    end
                end
            end
            ARF_BUS_ANSWER: begin
                s_d.bus = ARF_BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
            default: begin
                s_d.bus = ARF_BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
        endcase

        // software writes land at the answer edge; filter and previous
        // value have no write path at all
        if (do_write && avs_byteenable[0]) begin
            if (hit(avs_address, OFS_CTRL)) begin
                s_d.fmt = avs_writedata[CTRL_FMT_BIT];
                s_d.psis = avs_writedata[CTRL_PSIS_BIT];
                s_d.mode = arf_mode_t'(avs_writedata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
            end else if (hit(avs_address, OFS_CNT)) begin
                s_d.cnt = avs_writedata[7:0];
            end else if (hit(avs_address, OFS_RES_HI)) begin
                s_d.res_hi = avs_writedata[7:0];
            end else if (hit(avs_address, OFS_RES_LO)) begin
                s_d.res_lo = avs_writedata[7:0];
            end
        end
        if (do_write && avs_byteenable[1] && hit(avs_address, OFS_CTRL)) begin
            s_d.shift = avs_writedata[CTRL_SHIFT_MSB:CTRL_SHIFT_LSB];
        end

        // hardware events override a software write in the same cycle
        if (conv_start) begin
            if (s_q.cnt != CNT_MAX) begin
                s_d.cnt = 8'(s_q.cnt + 8'h01);
            end else begin
                s_d.cnt = CNT_MAX;
            end
            if (s_q.psis) begin
                s_d.prev_hi = s_q.filt[15:8];
                s_d.prev_lo = s_q.filt[7:0];
            end else begin
                // result bytes already carry the chosen justification
                s_d.prev_hi = s_q.res_hi;
                s_d.prev_lo = s_q.res_lo;
            end
        end

        if (conv_done) begin
            s_d.res_hi = fmt_hi;
            s_d.res_lo = fmt_lo;
            // other modes check on every conversion
            if (paced_mode(s_q.mode)) begin
                s_d.chk = (s_q.cnt >= repeat_threshold);
            end else begin
                s_d.chk = 1'b1;
            end
        end

        if (s_q.mode == ARF_MODE_LPF) begin
            s_d.filt = lpf_value;
        end else begin
            s_d.filt = shifted;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q.bus <= ARF_BUS_IDLE;
            s_q.waitreq <= 1'b1;
            s_q.rdata <= RDATA_UNMAPPED;
            s_q.fmt <= 1'b0;
            s_q.psis <= 1'b0;
            s_q.mode <= ARF_MODE_BASIC;
            s_q.shift <= SHIFT_RESET;
            s_q.cnt <= CNT_RESET;
            s_q.filt <= WORD16_RESET;
            s_q.res_hi <= BYTE_RESET;
            s_q.res_lo <= BYTE_RESET;
            s_q.prev_hi <= BYTE_RESET;
            s_q.prev_lo <= BYTE_RESET;
            s_q.chk <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign threshold_check = s_q.chk;
    assign filter_output = s_q.filt;
    assign result_format_bit = s_q.fmt;
    assign compute_mode = s_q.mode;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_bus_req;
        (avs_read || avs_write) && (s_q.bus == ARF_BUS_IDLE);
    endsequence

    sequence s_bus_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_bus_answer;
        s_bus_req |=> s_bus_ans;
    endproperty

    AST_BUS_ANSWER: assert property (p_bus_answer)
        else $error("bus answer not one cycle after request");

    // converter events as seen at one edge, with the state they meet
    sequence s_start_filt;
        conv_start && s_q.psis;
    endsequence

    sequence s_start_res;
        conv_start && !s_q.psis;
    endsequence

    sequence s_done_left;
        conv_done && !s_q.fmt;
    endsequence

    sequence s_done_right;
        conv_done && s_q.fmt;
    endsequence

    sequence s_done_early;
        conv_done && paced_mode(s_q.mode) && (s_q.cnt < repeat_threshold);
    endsequence

    sequence s_done_due;
        conv_done && paced_mode(s_q.mode) && (s_q.cnt >= repeat_threshold);
    endsequence

    sequence s_done_free;
        conv_done && !paced_mode(s_q.mode);
    endsequence

    property p_cnt_inc;
        conv_start && (s_q.cnt != CNT_MAX) |=> s_q.cnt == 8'($past(s_q.cnt) + 8'h01);
    endproperty

    AST_CNT_INC: assert property (p_cnt_inc)
        else $error("count did not step on trigger");

    property p_cnt_sat;
        conv_start && (s_q.cnt == CNT_MAX) |=> s_q.cnt == CNT_MAX;
    endproperty

    AST_CNT_SAT: assert property (p_cnt_sat)
        else $error("count wrapped past maximum");

    property p_chk_paced;
        s_done_early |=> !threshold_check;
    endproperty

    AST_CHK_PACED: assert property (p_chk_paced)
        else $error("threshold checked before count reached repeat value");

    property p_chk_due;
        s_done_due |=> threshold_check;
    endproperty

    AST_CHK_DUE: assert property (p_chk_due)
        else $error("threshold check missing once count reached repeat value");

    property p_chk_free;
        s_done_free |=> threshold_check;
    endproperty

    AST_CHK_FREE: assert property (p_chk_free)
        else $error("threshold check missing in unpaced mode");

    property p_chk_cause;
        threshold_check |-> $past(conv_done);
    endproperty

    AST_CHK_CAUSE: assert property (p_chk_cause)
        else $error("threshold check without conversion");

    // expected value worked out apart from the shared shifter net
    property p_filt_shift;
        (s_q.mode != ARF_MODE_LPF) |=> filter_output == $past(16'($signed(sum_accumulator) >>> s_q.shift));
    endproperty

    AST_FILT_SHIFT: assert property (p_filt_shift)
        else $error("filter output not shifted accumulator");

    property p_filt_lpf;
        (s_q.mode == ARF_MODE_LPF) |=> filter_output == $past(lpf_value);
    endproperty

    AST_FILT_LPF: assert property (p_filt_lpf)
        else $error("filter output not low-pass value");

    property p_res_left;
        s_done_left |=> (s_q.res_hi == $past(conv_value[9:2])) && (s_q.res_lo[7:6] == $past(conv_value[1:0]));
    endproperty

    AST_RES_LEFT: assert property (p_res_left)
        else $error("left justified result wrong");

    property p_res_right_hi;
        s_done_right |=> s_q.res_hi[1:0] == $past(conv_value[9:8]);
    endproperty

    AST_RES_RIGHT_HI: assert property (p_res_right_hi)
        else $error("right justified high byte wrong");

    property p_res_right_rsv;
        s_done_right |=> s_q.res_hi[7:2] == 6'h00;
    endproperty

    AST_RES_RIGHT_RSV: assert property (p_res_right_rsv)
        else $error("right justified high byte reserved bits not clear");

    property p_res_right_lo;
        s_done_right |=> s_q.res_lo == $past(conv_value[7:0]);
    endproperty

    AST_RES_RIGHT_LO: assert property (p_res_right_lo)
        else $error("right justified low byte wrong");

    property p_prev_filt;
        s_start_filt |=> {s_q.prev_hi, s_q.prev_lo} == $past(s_q.filt);
    endproperty

    AST_PREV_FILT: assert property (p_prev_filt)
        else $error("previous value missed filter output");

    property p_prev_res;
        s_start_res |=> (s_q.prev_hi == $past(s_q.res_hi)) && (s_q.prev_lo == $past(s_q.res_lo));
    endproperty

    AST_PREV_RES: assert property (p_prev_res)
        else $error("previous value missed result");

    property p_prev_ro;
        !conv_start |=> $stable(s_q.prev_hi) && $stable(s_q.prev_lo);
    endproperty

    AST_PREV_RO: assert property (p_prev_ro)
        else $error("previous value changed without conversion start");

    property p_read_prev;
        avs_read && (s_q.bus == ARF_BUS_IDLE) && hit(avs_address, OFS_PREV_HI)
            |=> avs_readdata == {24'h00_0000, $past(s_q.prev_hi)};
    endproperty

    AST_READ_PREV: assert property (p_read_prev)
        else $error("previous value high byte not readable");
endmodule : arf_regs

`default_nettype wire

// ---- arf_conv_model.sv ----
/*
 * Behavioural converter core: start pulse, then a done pulse with the result.
 * Assumes the bench raises req for one cycle while busy is low.
 */
`timescale 1ns/100ps
`default_nettype none

module arf_conv_model #(
    parameter int CONV_CYCLES = 3
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req,
    input wire logic [9:0] req_value,
    output logic conv_start,
    output logic conv_done,
    output logic [9:0] conv_value,
    output logic busy
);
    logic [3:0] cnt_q;
    logic [9:0] hold_q;
    assign busy = (cnt_q != 4'h0) || conv_done;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
            hold_q <= 10'h000;
            conv_start <= 1'b0;
            conv_done <= 1'b0;
            conv_value <= 10'h000;
        end else begin
            conv_start <= req && (cnt_q == 4'h0);
            conv_done <= (cnt_q == 4'h1);
            // value only valid with done; toggles otherwise so stale data is never mistaken
            conv_value <= (cnt_q == 4'h1) ? hold_q : ~conv_value;
            if (req && (cnt_q == 4'h0)) begin
                cnt_q <= 4'(CONV_CYCLES);
                hold_q <= req_value;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : arf_conv_model

`default_nettype wire

// ---- tb_top.sv ----
/*
 * Self-checking bench of the result and filter registers.
 * Assumes arf_pkg offsets and a one-cycle Avalon answer.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import arf_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] acc;
        logic [15:0] low_pass_filter_mode;
        logic [15:0] exp;
    } arf_row_t;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic conv_start, conv_done, threshold_check, result_format_bit, busy;
    logic [9:0] conv_value;
    logic [9:0] req_value = 10'h000;
    logic req = 1'b0;
    logic [15:0] sum_accumulator = 16'h0000;
    logic [15:0] lpf_value = 16'h0000;
    logic [7:0] repeat_threshold = 8'h00;
    logic [15:0] filter_output;
    logic [2:0] compute_mode;
    int mismatches = 0;
    int checks_done = 0;
    int pulses = 0;
    arf_row_t rows [4] = '{
        '{32'h0000_0010, 16'h1234, 16'h0000, 16'h1234},
        '{32'h0000_0320, 16'h8010, 16'h0000, 16'hF002},
        '{32'h0000_0730, 16'h7FFF, 16'h0000, 16'h00FF},
        '{32'h0000_0240, 16'h1234, 16'hBEEF, 16'hBEEF}};

    arf_regs i_arf_regs (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_start(conv_start), .conv_done(conv_done), .conv_value(conv_value),
        .sum_accumulator(sum_accumulator), .lpf_value(lpf_value),
        .repeat_threshold(repeat_threshold), .threshold_check(threshold_check),
        .filter_output(filter_output), .result_format_bit(result_format_bit),
        .compute_mode(compute_mode));
    arf_conv_model i_arf_conv_model (.clock(clock), .sys_rst(sys_rst), .req(req),
        .req_value(req_value), .conv_start(conv_start), .conv_done(conv_done),
        .conv_value(conv_value), .busy(busy));

    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (threshold_check === 1'b1) begin
            pulses++;
        end
    end

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // holds the request until waitrequest is sampled low, then idles one cycle
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clock);
        // only the watchdog ends a wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rd(input string name, input logic [5:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(name, q, {24'h00_0000, exp});
    endtask : rd
    task conv(input logic [9:0] v);
        req <= 1'b1;
        req_value <= v;
        @(posedge clock);
        req <= 1'b0;
        @(posedge clock);
        while (busy !== 1'b0) begin
            @(posedge clock);
        end
        repeat (2) @(posedge clock);
    endtask : conv

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd("count", OFS_CNT, 8'h00);
        rd("ctrl", OFS_CTRL, 8'h00);
        $display("TEST reset done");
        foreach (rows[i]) begin
            sum_accumulator <= rows[i].acc;
            lpf_value <= rows[i].low_pass_filter_mode;
            wr(OFS_CTRL, rows[i].ctrl);
            check("mode", 32'(compute_mode), 32'(rows[i].ctrl[6:4]));
            rd("filt_hi", OFS_FILT_HI, rows[i].exp[15:8]);
            rd("filt_lo", OFS_FILT_LO, rows[i].exp[7:0]);
            check("filter", 32'(filter_output), 32'(rows[i].exp));
        end
        $display("TEST filter rows done");
        wr(OFS_FILT_HI, 32'h0000_0000);
        wr(OFS_PREV_LO, 32'h0000_00FF);
        wr(6'h20, 32'h0000_00FF);
        rd("filt_hi_ro", OFS_FILT_HI, 8'hBE);
        rd("prev_lo_ro", OFS_PREV_LO, 8'h00);
        rd("unmapped", 6'h20, 8'h00);
        $display("TEST read only done");
        wr(OFS_CTRL, 32'h0000_0000);
        pulses = 0;
        conv(10'h2A5);
        rd("res_hi_left", OFS_RES_HI, 8'hA9);
        rd("res_lo_left", OFS_RES_LO, 8'h40);
        conv(10'h0F3);
        rd("prev_hi_left", OFS_PREV_HI, 8'hA9);
        rd("prev_lo_left", OFS_PREV_LO, 8'h40);
        wr(OFS_CTRL, 32'h0000_0001);
        check("format", 32'(result_format_bit), 32'd1);
        conv(10'h2A5);
        rd("res_hi_right", OFS_RES_HI, 8'h02);
        rd("res_lo_right", OFS_RES_LO, 8'hA5);
        conv(10'h1C4);
        rd("prev_hi_right", OFS_PREV_HI, 8'h02);
        rd("prev_lo_right", OFS_PREV_LO, 8'hA5);
        sum_accumulator <= 16'hC35A;
        wr(OFS_CTRL, 32'h0000_0013);
        conv(10'h000);
        rd("prev_hi_filt", OFS_PREV_HI, 8'hC3);
        rd("prev_lo_filt", OFS_PREV_LO, 8'h5A);
        check("pulses_free", 32'(pulses), 32'd5);
        $display("TEST format and previous done");
        repeat_threshold <= 8'hFF;
        wr(OFS_CNT, 32'h0000_00FD);
        wr(OFS_CTRL, 32'h0000_0020);
        pulses = 0;
        repeat (4) conv(10'h155);
        rd("count_sat", OFS_CNT, 8'hFF);
        check("pulses", 32'(pulses), 32'd3);
        $display("TEST count done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd("count_rst", OFS_CNT, 8'h00);
        rd("ctrl_rst", OFS_CTRL, 8'h00);
        $display("TEST second reset done");
        complete_run;
    end
endmodule : tb_top

`default_nettype wire
